//--- hw/ee_device.sv
// Purpose: Memory end: command decode, read shifter, self-timed programming
// Assumes: Serial clock is a synchronous input sampled on clk
// Notes:   Array contents are not reset; they model nonvolatile storage
module ee_device #(
  parameter int WORD_PROG_CYCLES = ee_pkg::WORD_PROG_CYC,
  parameter int ERASE_ALL_CYCLES = ee_pkg::ERASE_ALL_CYC,
  parameter int WRITE_ALL_CYCLES = ee_pkg::WRITE_ALL_CYC
) (
  // Clock and reset
  input  wire logic  clk,
  input  wire logic  rst,
  // Serial link
  ee_link_if.device  link,
  // Status for the user side
  output logic       prog_busy,
  output logic       prog_locked
);
  import ee_pkg::*;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_OPC  = 5'h02,
    ST_ADDR = 5'h04,
    ST_RDAT = 5'h08,
    ST_WDAT = 5'h10
  } ee_dev_st_e;

  ee_dev_st_e          st_ff;
  ee_dev_st_e          nxt_st;
  logic                sclk_q_ff;
  logic                rise;
  logic                wide_ff;
  logic [1:0]          opc_ff;
  logic [BADDR_W-1:0]  addr_ff;
  logic [BADDR_W-1:0]  addr_in;
  logic [DATA_W-1:0]   wdat_ff;
  logic [DATA_W-1:0]   wdat_in;
  logic [DATA_W-1:0]   rd_sr_ff;
  logic [BADDR_W-1:0]  rd_ptr_ff;
  logic [4:0]          cnt_ff;
  logic [4:0]          addr_last;
  logic [4:0]          data_last;
  logic                out_ff;
  logic                locked_ff;
  logic                busy_ff;
  logic                pend_ff;
  logic                erase_ff;
  logic [TIMER_W-1:0]  timer_ff;
  logic [ADDR_W-1:0]   pgm_addr_ff;
  logic [DATA_W-1:0]   pgm_data_ff;
  logic [DATA_W-1:0]   pgm_mask_ff;
  logic                pgm_all_ff;
  logic                pgm_write_ff;
  logic [1:0]          sub_in;
  logic                addr_done;
  logic                data_done;
  logic                start_seen;
  logic                cmd_erase;
  logic                cmd_erase_all;
  logic                cmd_write;
  logic                cmd_write_all;
  logic                prog_go;
  logic                program_now;
  logic                reading;
  logic                status_on;
  logic [BADDR_W-1:0]  pgm_src;
  logic [DATA_W-1:0]   mem_ff [WORDS];

  assign addr_last = wide_ff ? 5'(ADDR_W - 1) : 5'(BADDR_W - 1);
  assign data_last = wide_ff ? 5'(DATA_W - 1) : 5'(BDATA_W - 1);
  assign addr_in   = {addr_ff[BADDR_W-2:0], link.serial_in};
  assign wdat_in   = {wdat_ff[DATA_W-2:0], link.serial_in};
  assign sub_in    = wide_ff ? addr_in[ADDR_W-1:ADDR_W-2] : addr_in[BADDR_W-1:BADDR_W-2];

  assign rise       = link.serial_clk && !sclk_q_ff;
  assign addr_done  = rise && st_ff == ST_ADDR && cnt_ff == addr_last;
  assign data_done  = rise && st_ff == ST_WDAT && cnt_ff == data_last;
  assign start_seen = rise && st_ff == ST_IDLE && nxt_st == ST_OPC;

  assign cmd_erase = addr_done && opc_ff == OPC_ERASE;
  assign cmd_erase_all  = addr_done && opc_ff == OPC_SPECIAL && sub_in == SUB_ERASE_ALL;
  assign cmd_write = data_done && opc_ff == OPC_WRITE;
  assign cmd_write_all  = data_done && opc_ff == OPC_SPECIAL;
  assign prog_go   = (cmd_erase || cmd_erase_all || cmd_write || cmd_write_all) && !locked_ff;
  assign pgm_src   = cmd_erase ? addr_in : addr_ff;

  // read one word or byte, byte left-aligned
  function automatic logic [DATA_W-1:0] fetch(input logic [BADDR_W-1:0] a, input logic w);
    logic [DATA_W-1:0] word;
    word = mem_ff[w ? a[ADDR_W-1:0] : a[BADDR_W-1:1]];
    if (w) begin
      return word;
    end
    return a[0] ? {word[DATA_W-1:BDATA_W], {BDATA_W{1'b0}}} :
                  {word[BDATA_W-1:0], {BDATA_W{1'b0}}};
  endfunction

  always_ff @(posedge clk) begin
    if (rst) begin
      sclk_q_ff <= 1'b0;
    end else begin
      sclk_q_ff <= link.serial_clk;
    end
  end

  always_comb begin
    nxt_st = st_ff;
    if (!link.device_select) begin
      nxt_st = ST_IDLE;
    end else if (rise) begin
      case (st_ff)
        ST_IDLE: begin
          // A start is refused while a cycle runs; the status stays visible
          if (link.serial_in && !busy_ff) begin
            nxt_st = ST_OPC;
          end
        end
        ST_OPC: begin
          if (cnt_ff == 5'h01) begin
            nxt_st = ST_ADDR;
          end
        end
        ST_ADDR: begin
          if (cnt_ff == addr_last) begin
            if (opc_ff == OPC_READ) begin
              nxt_st = ST_RDAT;
            end else if (opc_ff == OPC_WRITE ||
                         (opc_ff == OPC_SPECIAL && sub_in == SUB_WRITE_ALL)) begin
              nxt_st = ST_WDAT;
            end else begin
              nxt_st = ST_IDLE;
            end
          end
        end
        ST_RDAT: nxt_st = ST_RDAT;
        ST_WDAT: begin
          if (cnt_ff == data_last) begin
            nxt_st = ST_IDLE;
          end
        end
        default: nxt_st = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= ST_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || nxt_st != st_ff) begin
      cnt_ff <= 5'h00;
    end else if (rise) begin
      cnt_ff <= (st_ff == ST_RDAT && cnt_ff == data_last) ? 5'h00 : cnt_ff + 5'h01;
    end
  end

  // layout caught at the start bit
  always_ff @(posedge clk) begin
    if (rst) begin
      wide_ff <= 1'b1;
      opc_ff  <= 2'h0;
      addr_ff <= '0;
      wdat_ff <= '0;
    end else begin
      if (start_seen) begin
        wide_ff <= link.word_width_select;
      end
      if (rise && st_ff == ST_OPC) begin
        opc_ff <= {opc_ff[0], link.serial_in};
      end
      if (rise && st_ff == ST_ADDR) begin
        addr_ff <= addr_in;
      end
      if (rise && st_ff == ST_WDAT) begin
        wdat_ff <= wdat_in;
      end
    end
  end

  // dummy zero, then data MSB first
  always_ff @(posedge clk) begin
    if (rst) begin
      out_ff    <= 1'b0;
      rd_sr_ff  <= '0;
      rd_ptr_ff <= '0;
    end else if (addr_done && opc_ff == OPC_READ) begin
      out_ff    <= 1'b0;
      rd_sr_ff  <= fetch(addr_in, wide_ff);
      rd_ptr_ff <= addr_in;
    end else if (rise && st_ff == ST_RDAT) begin
      out_ff <= rd_sr_ff[DATA_W-1];
      // sequential read wraps at the top
      if (cnt_ff == data_last) begin
        rd_ptr_ff <= rd_ptr_ff + 7'h01;
        rd_sr_ff  <= fetch(rd_ptr_ff + 7'h01, wide_ff);
      end else begin
        rd_sr_ff <= rd_sr_ff << 1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      locked_ff <= 1'b1;
    end else if (addr_done && opc_ff == OPC_SPECIAL && sub_in == SUB_UNLOCK) begin
      locked_ff <= 1'b0;
    end else if (addr_done && opc_ff == OPC_SPECIAL && sub_in == SUB_LOCK) begin
      locked_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      busy_ff      <= 1'b0;
      erase_ff     <= 1'b0;
      timer_ff     <= '0;
      pgm_addr_ff  <= '0;
      pgm_data_ff  <= '0;
      pgm_mask_ff  <= '0;
      pgm_all_ff   <= 1'b0;
      pgm_write_ff <= 1'b0;
    end else begin
      erase_ff <= prog_go;
      if (prog_go) begin
        busy_ff      <= 1'b1;
        timer_ff     <= cmd_write_all ? TIMER_W'(WRITE_ALL_CYCLES) :
                        cmd_erase_all ? TIMER_W'(ERASE_ALL_CYCLES) : TIMER_W'(WORD_PROG_CYCLES);
        pgm_all_ff   <= cmd_erase_all || cmd_write_all;
        pgm_write_ff <= cmd_write || cmd_write_all;
        pgm_addr_ff  <= wide_ff ? pgm_src[ADDR_W-1:0] : pgm_src[BADDR_W-1:1];
        pgm_data_ff  <= wide_ff ? wdat_in : {2{wdat_in[BDATA_W-1:0]}};
        if (wide_ff || cmd_erase_all || cmd_write_all) begin
          pgm_mask_ff <= ERASED_WORD;
        end else begin
          pgm_mask_ff <= pgm_src[0] ? {ERASED_WORD[DATA_W-1:BDATA_W], {BDATA_W{1'b0}}} :
                                      {{BDATA_W{1'b0}}, ERASED_WORD[BDATA_W-1:0]};
        end
      end else if (busy_ff) begin
        timer_ff <= timer_ff - 1'b1;
        if (timer_ff == TIMER_W'(1)) begin
          busy_ff <= 1'b0;
        end
      end
    end
  end

  assign program_now = busy_ff && timer_ff == TIMER_W'(1);

  // erase at cycle start, program at its end
  for (genvar i = 0; i < WORDS; i++) begin : g_word
    logic hit;
    assign hit = pgm_all_ff || pgm_addr_ff == ADDR_W'(i);
    always_ff @(posedge clk) begin
      if (erase_ff && hit) begin
        mem_ff[i] <= mem_ff[i] | pgm_mask_ff;
      end else if (program_now && pgm_write_ff && hit) begin
        mem_ff[i] <= (mem_ff[i] & ~pgm_mask_ff) | (pgm_data_ff & pgm_mask_ff);
      end
    end
  end

  // status shown until the next start bit
  always_ff @(posedge clk) begin
    if (rst) begin
      pend_ff <= 1'b0;
    end else if (cmd_erase || cmd_erase_all || cmd_write || cmd_write_all) begin
      pend_ff <= 1'b1;
    end else if (start_seen) begin
      pend_ff <= 1'b0;
    end
  end

  assign reading   = st_ff == ST_RDAT;
  assign status_on = st_ff == ST_IDLE && (busy_ff || pend_ff);
  // low busy, high ready; idle output released
  assign link.serial_out_oe = link.device_select && (reading || status_on);
  assign link.serial_out    = reading ? out_ff : !busy_ff;
  assign prog_busy          = busy_ff;
  assign prog_locked        = locked_ff;
endmodule

//--- hw/ee_pkg.sv
// Purpose: Shared constants for the serial memory device end and its controller end
// Assumes: One 20 MHz clock; the controller makes the serial clock by division
// Notes:   64 words of 16 bits; byte-wide access maps onto the same array
// How it works
// - Width select chooses byte or word layout
// - Array is 64 words, six-bit address
// - Start bit, opcode 10, read takes 25
// - Unlock is 00 then 11, no output
// - Word erase opcode 11, then status
// - Erase all is 00 then 10
// - Word write opcode 01 plus 16 bits
// - Write all is 00 then 01, data
// - Lock is 00 then 00, no output
// - Status on output while programming
// - Self-timed cycles; write erases its word, or in byte mode its byte, first
// - Write all erases whole array first
// - Word cycle 4 ms typical, 10 max
// - Erase all 8 ms typical, 15 max
// - Write all 16 ms typical, 30 max
// - Low means busy, high means ready
// - Locked after reset until unlock command
// - Held select continues read at next word
// - Byte read: seven address, eight data, 18
package ee_pkg;
  localparam int CLK_MHZ = 20;
  localparam int ADDR_W  = 6;
  localparam int BADDR_W = 7;
  localparam int DATA_W  = 16;
  localparam int BDATA_W = 8;
  localparam int WORDS   = 64;
  localparam int TX_W    = 1 + 2 + BADDR_W + DATA_W;
  localparam int TIMER_W = 20;

  localparam logic [1:0] OPC_SPECIAL   = 2'h0;
  localparam logic [1:0] OPC_WRITE     = 2'h1;
  localparam logic [1:0] OPC_READ      = 2'h2;
  localparam logic [1:0] OPC_ERASE     = 2'h3;
  localparam logic [1:0] SUB_LOCK      = 2'h0;
  localparam logic [1:0] SUB_WRITE_ALL = 2'h1;
  localparam logic [1:0] SUB_ERASE_ALL = 2'h2;
  localparam logic [1:0] SUB_UNLOCK    = 2'h3;

  localparam logic [DATA_W-1:0] ERASED_WORD = 16'hFFFF;

  // Programming times, typical figures
  localparam int WORD_PROG_US  = 4000;
  localparam int ERASE_ALL_US  = 8000;
  localparam int WRITE_ALL_US  = 16000;
  localparam int WORD_PROG_CYC = WORD_PROG_US * CLK_MHZ;
  localparam int ERASE_ALL_CYC = ERASE_ALL_US * CLK_MHZ;
  localparam int WRITE_ALL_CYC = WRITE_ALL_US * CLK_MHZ;

  // Link timing seen by the controller, least times rounded up
  localparam int SCLK_HALF_NS  = 500;
  localparam int CS_LOW_NS     = 250;
  localparam int STATUS_NS     = 500;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int CS_LOW_CYC    = (CS_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int STATUS_CYC    = (STATUS_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [2:0] {
    EE_READ      = 3'h0,
    EE_WRITE     = 3'h1,
    EE_ERASE     = 3'h2,
    EE_ERASE_ALL = 3'h3,
    EE_WRITE_ALL = 3'h4,
    EE_UNLOCK    = 3'h5,
    EE_LOCK      = 3'h6
  } ee_op_e;
endpackage

//--- hw/ee_link_if.sv
// Purpose: Three-wire serial link between the memory and its controller
// Assumes: All signals change on the shared 20 MHz clock
// Notes:   The output line is valid only while its enable is high
interface ee_link_if;
  logic device_select;
  logic serial_clk;
  logic serial_in;
  logic serial_out;
  logic serial_out_oe;
  logic word_width_select;

  modport device (
    input  device_select,
    input  serial_clk,
    input  serial_in,
    input  word_width_select,
    output serial_out,
    output serial_out_oe
  );

  modport ctrl (
    output device_select,
    output serial_clk,
    output serial_in,
    output word_width_select,
    input  serial_out,
    input  serial_out_oe
  );
endinterface

//--- hw/ee_ctrl.sv
// Purpose: Controller end: frames commands, clocks the link, polls status
// Assumes: Serial clock is clk divided by two half periods of 500 ns
// Notes:   One command at a time; a read may fetch up to 16 words in a row
module ee_ctrl (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // Serial link
  ee_link_if.ctrl                     link,
  // Command request
  input  wire logic                   cmd_valid,
  output logic                        cmd_ready,
  input  wire ee_pkg::ee_op_e         cmd_op,
  input  wire logic [ee_pkg::BADDR_W-1:0] cmd_addr,
  input  wire logic [ee_pkg::DATA_W-1:0]  cmd_wdata,
  input  wire logic [3:0]             cmd_words,
  input  wire logic                   width_sel,
  // Answers
  output logic                        rd_valid,
  output logic [ee_pkg::DATA_W-1:0]   rd_data,
  output logic                        done
);
  import ee_pkg::*;

  typedef enum logic [3:0] {
    H_IDLE  = 4'h1,
    H_SHIFT = 4'h2,
    H_GAP   = 4'h4,
    H_POLL  = 4'h8
  } ee_ctrl_st_e;

  ee_ctrl_st_e      st_ff;
  logic [15:0]      cnt_ff;
  logic             cs_ff;
  logic             sclk_ff;
  logic             wide_ff;
  logic             prog_ff;
  logic [TX_W-1:0]  tx_ff;
  logic [TX_W-1:0]  frame;
  logic [8:0]       rises_ff;
  logic [8:0]       nbits_ff;
  logic [8:0]       total_ff;
  logic [8:0]       nbits;
  logic [8:0]       dbits;
  logic [4:0]       rxc_ff;
  logic [DATA_W-1:0] rx_ff;
  logic [DATA_W-1:0] rx_in;
  logic [1:0]       opc;
  logic [1:0]       sub;
  logic             tick;

  always_comb begin
    opc = OPC_SPECIAL;
    sub = SUB_LOCK;
    case (cmd_op)
      EE_READ:      opc = OPC_READ;
      EE_WRITE:     opc = OPC_WRITE;
      EE_ERASE:     opc = OPC_ERASE;
      EE_ERASE_ALL: sub = SUB_ERASE_ALL;
      EE_WRITE_ALL: sub = SUB_WRITE_ALL;
      EE_UNLOCK:    sub = SUB_UNLOCK;
      default:      sub = SUB_LOCK;
    endcase
  end

  // frame left-aligned, MSB first; word or byte layout
  always_comb begin
    dbits = width_sel ? 9'(DATA_W) : 9'(BDATA_W);
    nbits = width_sel ? 9'(3 + ADDR_W) : 9'(3 + BADDR_W);
    if (width_sel) begin
      frame = {1'b1, opc, opc == OPC_SPECIAL ? {sub, 4'h0} : cmd_addr[ADDR_W-1:0],
               cmd_wdata, 1'b0};
    end else begin
      frame = {1'b1, opc, opc == OPC_SPECIAL ? {sub, 5'h00} : cmd_addr,
               cmd_wdata[BDATA_W-1:0], {BDATA_W{1'b0}}};
    end
  end

  assign tick  = cnt_ff == 16'(SCLK_HALF_CYC - 1);
  assign rx_in = {rx_ff[DATA_W-2:0], link.serial_out};

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff    <= H_IDLE;
      cnt_ff   <= 16'h0000;
      cs_ff    <= 1'b0;
      sclk_ff  <= 1'b0;
      wide_ff  <= 1'b1;
      prog_ff  <= 1'b0;
      tx_ff    <= '0;
      rises_ff <= 9'h000;
      nbits_ff <= 9'h000;
      total_ff <= 9'h000;
      rxc_ff   <= 5'h00;
      rx_ff    <= '0;
      rd_valid <= 1'b0;
      rd_data  <= '0;
      done     <= 1'b0;
    end else begin
      rd_valid <= 1'b0;
      done     <= 1'b0;
      case (st_ff)
        H_IDLE: begin
          if (cmd_valid) begin
            st_ff    <= H_SHIFT;
            cs_ff    <= 1'b1;
            cnt_ff   <= 16'h0000;
            wide_ff  <= width_sel;
            tx_ff    <= frame;
            rises_ff <= 9'h000;
            rxc_ff   <= 5'h00;
            nbits_ff <= (cmd_op == EE_WRITE || cmd_op == EE_WRITE_ALL) ? nbits + dbits : nbits;
            // read length grows by one word per extra count
            total_ff <= (cmd_op == EE_READ) ?
                        nbits + 9'(dbits * ({5'h00, cmd_words} + 9'h001)) :
                        (cmd_op == EE_WRITE || cmd_op == EE_WRITE_ALL) ? nbits + dbits : nbits;
            prog_ff  <= cmd_op inside {EE_WRITE, EE_ERASE, EE_ERASE_ALL, EE_WRITE_ALL};
          end
        end
        H_SHIFT: begin
          cnt_ff <= tick ? 16'h0000 : cnt_ff + 16'h0001;
          if (tick) begin
            sclk_ff <= !sclk_ff;
            if (!sclk_ff) begin
              rises_ff <= rises_ff + 9'h001;
            end else begin
              // Change data on the falling edge so the rise samples a settled bit
              tx_ff <= tx_ff << 1;
              if (rises_ff > nbits_ff) begin
                rx_ff  <= rx_in;
                rxc_ff <= rxc_ff + 5'h01;
                if (rxc_ff == 5'(dbits - 9'h001)) begin
                  rxc_ff   <= 5'h00;
                  rd_valid <= 1'b1;
                  rd_data  <= wide_ff ? rx_in : {{BDATA_W{1'b0}}, rx_in[BDATA_W-1:0]};
                end
              end
              if (rises_ff == total_ff) begin
                st_ff  <= H_GAP;
                cs_ff  <= 1'b0;
                cnt_ff <= 16'h0000;
              end
            end
          end
        end
        H_GAP: begin
          cnt_ff <= cnt_ff + 16'h0001;
          if (cnt_ff == 16'(CS_LOW_CYC - 1)) begin
            cnt_ff <= 16'h0000;
            if (prog_ff) begin
              prog_ff <= 1'b0;
              cs_ff   <= 1'b1;
              st_ff   <= H_POLL;
            end else begin
              done  <= 1'b1;
              st_ff <= H_IDLE;
            end
          end
        end
        H_POLL: begin
          if (cnt_ff < 16'(STATUS_CYC)) begin
            cnt_ff <= cnt_ff + 16'h0001;
          end else if (link.serial_out_oe && link.serial_out) begin
            cs_ff  <= 1'b0;
            cnt_ff <= 16'h0000;
            st_ff  <= H_GAP;
          end
        end
        default: st_ff <= H_IDLE;
      endcase
    end
  end

  assign cmd_ready              = st_ff == H_IDLE;
  assign link.device_select     = cs_ff;
  assign link.serial_clk        = sclk_ff;
  assign link.serial_in         = tx_ff[TX_W-1];
  assign link.word_width_select = wide_ff;
endmodule

//--- tb/ee_link_properties.sv
// Purpose: Link-level timing and framing properties between the two ends
// Assumes: All link signals change on clk; sclk is a level made from clk
// Notes:   Data values are left to the bench; here only the wire behaviour
module ee_link_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link signals
  input wire logic device_select,
  input wire logic serial_clk,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic word_width_select
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       sclk_q_ff;
  logic [8:0] rises_ff;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  always_ff @(posedge clk) begin
    sclk_q_ff <= serial_clk;
  end

  // Rises per frame; cleared whenever select is low
  always_ff @(posedge clk) begin
    if (rst || !device_select) begin
      rises_ff <= 9'h000;
    end else if (serial_clk && !sclk_q_ff) begin
      rises_ff <= rises_ff + 9'h001;
    end
  end

  a_oe_needs_select: assert property (
    serial_out_oe |-> device_select) else $error("output driven while deselected");
  a_sclk_idle_low: assert property (
    !device_select |-> !serial_clk) else $error("serial clock high while deselected");
  a_din_at_fall: assert property (
    $changed(serial_in) && device_select && $past(device_select) |-> $fell(serial_clk))
    else $error("serial input moved away from a clock fall");
  a_sclk_high_half: assert property (
    $rose(serial_clk) |-> serial_clk[*8] ##1 serial_clk[*2] ##1 !serial_clk)
    else $error("serial clock high time wrong");
  a_sclk_low_half: assert property (
    $fell(serial_clk) |-> !serial_clk[*8] ##1 !serial_clk) else $error("clock low too short");
  a_frame_len: assert property (
    $fell(device_select) |-> (word_width_select ?
      (rises_ff == 9'h000 || rises_ff == 9'h009 || (rises_ff >= 9'h019 && rises_ff % 16 == 9)) :
      (rises_ff == 9'h000 || rises_ff == 9'h00A || (rises_ff >= 9'h012 && rises_ff % 8 == 2))))
    else $error("frame clock count wrong");
  // Status stays shown until the next start bit, so a release with select high
  // is only legal at the start bit's clock high phase
  a_oe_release: assert property (
    $fell(serial_out_oe) |-> !device_select || (serial_clk && serial_in))
    else $error("output released inside a frame");
  a_ready_holds: assert property (
    serial_out_oe && $past(serial_out_oe) && $past(serial_out) && !serial_clk |-> serial_out)
    else $error("ready went back to busy");
  a_cs_gap: assert property (
    $fell(device_select) |-> !device_select[*5]) else $error("select low time too short");
  a_width_steady: assert property (
    device_select && $past(device_select) |-> $stable(word_width_select))
    else $error("width select moved in a frame");
endmodule

//--- tb/serial_eeprom_command_logic_test.sv
// Purpose: Drives the controller end against the memory end, checks results
// Assumes: Short programming counts so a run stays under ten thousand cycles
// Notes:   Busy length is counted on prog_busy; data via the read command
module serial_eeprom_command_logic_test;
  timeunit 1ns;
  timeprecision 1ns;
  import ee_pkg::*;
  localparam int WORD_N  = 20;
  localparam int ERALL_N = 40;
  localparam int WRALL_N = 80;

  logic        clk = 1'b0;
  logic        rst;
  logic        cmd_valid;
  logic        cmd_ready;
  ee_op_e      cmd_op;
  logic [6:0]  cmd_addr;
  logic [15:0] cmd_wdata;
  logic [3:0]  cmd_words;
  logic        width_sel;
  logic        rd_valid;
  logic [15:0] rd_data;
  logic        done;
  logic        prog_busy;
  logic        prog_locked;
  logic [15:0] rdq[$];
  int          busy_cyc;
  int          mismatches = 0;
  int          num_checks = 0;

  ee_link_if link ();

  ee_device #(.WORD_PROG_CYCLES(WORD_N), .ERASE_ALL_CYCLES(ERALL_N),
              .WRITE_ALL_CYCLES(WRALL_N)) i_ee_device (
    .clk(clk), .rst(rst), .link(link), .prog_busy(prog_busy), .prog_locked(prog_locked));

  ee_ctrl i_ee_ctrl (
    .clk(clk), .rst(rst), .link(link), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_words(cmd_words),
    .width_sel(width_sel), .rd_valid(rd_valid), .rd_data(rd_data), .done(done));

  ee_link_properties i_ee_link_properties (
    .clk(clk), .rst(rst), .device_select(link.device_select), .serial_clk(link.serial_clk),
    .serial_in(link.serial_in), .serial_out(link.serial_out),
    .serial_out_oe(link.serial_out_oe), .word_width_select(link.word_width_select));

  always #25 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // One command through the controller; gathers read words and busy cycles
  task automatic do_cmd(input ee_op_e op, input logic [6:0] a, input logic [15:0] d,
                        input logic [3:0] n, input logic ws);
    int k;
    rdq.delete();
    busy_cyc = 0;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op    <= op;
    cmd_addr  <= a;
    cmd_wdata <= d;
    cmd_words <= n;
    width_sel <= ws;
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
    check(cmd_ready, 0);
    for (k = 0; k < 4000 && done !== 1'b1; k++) begin
      @(posedge clk);
      #1;
      if (rd_valid === 1'b1) rdq.push_back(rd_data);
      if (prog_busy === 1'b1) busy_cyc++;
    end
    check(done, 1);
  endtask

  initial begin
    #(50 * 40000);
    mismatches++;
    report_and_stop();
  end

  initial begin
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = EE_READ;
    cmd_addr = 7'h00;
    cmd_wdata = 16'h0000;
    cmd_words = 4'h0;
    width_sel = 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    #1;
    check(prog_locked, 1);
    check(cmd_ready, 1);
    do_cmd(EE_WRITE, 7'h05, 16'h1234, 4'h0, 1'b1);
    check(busy_cyc, 0);
    do_cmd(EE_UNLOCK, 7'h00, 16'h0000, 4'h0, 1'b1);
    check(prog_locked, 0);
    do_cmd(EE_ERASE_ALL, 7'h00, 16'h0000, 4'h0, 1'b1);
    check(busy_cyc, ERALL_N);
    do_cmd(EE_READ, 7'h03, 16'h0000, 4'h0, 1'b1);
    check(rdq[0], 16'hFFFF);
    do_cmd(EE_WRITE, 7'h05, 16'h1234, 4'h0, 1'b1);
    check(busy_cyc, WORD_N);
    do_cmd(EE_WRITE, 7'h06, 16'h00FF, 4'h0, 1'b1);
    do_cmd(EE_WRITE, 7'h06, 16'hFF00, 4'h0, 1'b1);
    do_cmd(EE_READ, 7'h05, 16'h0000, 4'h1, 1'b1);
    check(rdq[0], 16'h1234);
    check(rdq[1], 16'hFF00);
    do_cmd(EE_ERASE, 7'h05, 16'h0000, 4'h0, 1'b1);
    check(busy_cyc, WORD_N);
    do_cmd(EE_READ, 7'h05, 16'h0000, 4'h0, 1'b1);
    check(rdq[0], 16'hFFFF);
    do_cmd(EE_WRITE_ALL, 7'h00, 16'hA5C3, 4'h0, 1'b1);
    check(busy_cyc, WRALL_N);
    do_cmd(EE_WRITE, 7'h00, 16'h1357, 4'h0, 1'b1);
    // Sequential read across the top of the array
    do_cmd(EE_READ, 7'h3E, 16'h0000, 4'h2, 1'b1);
    check(rdq[0], 16'hA5C3);
    check(rdq[1], 16'hA5C3);
    check(rdq[2], 16'h1357);
    do_cmd(EE_READ, 7'h00, 16'h0000, 4'h1, 1'b0);
    check(rdq[0][7:0], 8'h57);
    check(rdq[1][7:0], 8'h13);
    // Byte write to the upper half of word 0 leaves the lower half alone
    do_cmd(EE_WRITE, 7'h01, 16'h009A, 4'h0, 1'b0);
    check(busy_cyc, WORD_N);
    do_cmd(EE_READ, 7'h00, 16'h0000, 4'h0, 1'b1);
    check(rdq[0], 16'h9A57);
    do_cmd(EE_LOCK, 7'h00, 16'h0000, 4'h0, 1'b1);
    check(prog_locked, 1);
    do_cmd(EE_ERASE, 7'h00, 16'h0000, 4'h0, 1'b1);
    check(busy_cyc, 0);
    do_cmd(EE_READ, 7'h00, 16'h0000, 4'h0, 1'b1);
    check(rdq[0], 16'h9A57);
    report_and_stop();
  end
endmodule
